/* File: logic/gsrb_pad_unused.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: logic/gsrb_regs.vh */
`ifndef GSRB_REGS_VH
`define GSRB_REGS_VH

// Word window of the status bank
`define GSRB_WORD_BASE 16'h07d0
`define GSRB_NUM_WORDS 16'h0008
`define GSRB_BANK_BYTES 16
`define GSRB_NUM_AXES 4

// Byte offsets inside the bank
`define GSRB_GRIPPER_STATE 4'h0
`define GSRB_AXIS_CONTACT_STATE 4'h1
`define GSRB_FAULT_CODE 4'h2
`define GSRB_FINGER_A_REQUEST_ECHO 4'h3
`define GSRB_FINGER_A_ACTUAL_POSITION 4'h4
`define GSRB_FINGER_A_MOTOR_CURRENT 4'h5
`define GSRB_FINGER_B_REQUEST_ECHO 4'h6
`define GSRB_FINGER_B_ACTUAL_POSITION 4'h7
`define GSRB_FINGER_B_MOTOR_CURRENT 4'h8
`define GSRB_FINGER_C_REQUEST_ECHO 4'h9
`define GSRB_FINGER_C_ACTUAL_POSITION 4'ha
`define GSRB_FINGER_C_MOTOR_CURRENT 4'hb
`define GSRB_SCISSOR_REQUEST_ECHO 4'hc
`define GSRB_SCISSOR_ACTUAL_POSITION 4'hd
`define GSRB_SCISSOR_MOTOR_CURRENT 4'he
`define GSRB_PAD_BYTE 4'hf

// Axis indices
`define GSRB_AX_A 2'h0
`define GSRB_AX_B 2'h1
`define GSRB_AX_C 2'h2
`define GSRB_AX_S 2'h3

// Gripper state field codes
`define GSRB_ST_RESET 2'h0
`define GSRB_ST_ACTIVATING 2'h1
`define GSRB_ST_MODE_CHANGE 2'h2
`define GSRB_ST_READY 2'h3

// Contact and motion codes
`define GSRB_CT_MOVING 2'h0
`define GSRB_CT_STOP_OPEN 2'h1
`define GSRB_CT_STOP_CLOSE 2'h2
`define GSRB_CT_AT_REQUEST 2'h3
`define GSRB_MS_MOVING 2'h0
`define GSRB_MS_SOME_STOPPED 2'h1
`define GSRB_MS_ALL_STOPPED 2'h2
`define GSRB_MS_ALL_REACHED 2'h3

// Fault codes
`define GSRB_FLT_NONE 4'h0
`define GSRB_FLT_WAIT_ACT 4'h5
`define GSRB_FLT_WAIT_MODE 4'h6
`define GSRB_FLT_NO_ACT 4'h7
`define GSRB_FLT_COMM 4'h9
`define GSRB_FLT_INTERF 4'ha
`define GSRB_FLT_RELEASING 4'hb
`define GSRB_FLT_ACT_FAIL 4'hd
`define GSRB_FLT_INTERF_LONG 4'he
`define GSRB_FLT_RELEASED 4'hf
`define GSRB_FLT_PAD 4'h0

// Timing
`define GSRB_CLK_HZ 100000000
`define GSRB_INTERF_S 20
`define GSRB_BLINK_MS 250
`define GSRB_MS_PER_S 1000

`endif

/* File: logic/gsrb_status_bank.v */
// Notes on behaviour
// R1: init status mirrors activation request
// R2: operation mode mirrors requested grasp mode
// R3: action status mirrors go-to request
// R4: gripper state: reset, activating, mode change, ready
// R5: motion status summarises finger stops
// R6: byte 0 packs motion, state, action, mode, init
// R7: per-axis contact code: moving, open, close, reached
// R8: byte 1 packs scissor, C, B, A contacts
// R9: stopped axis holds until re-armed
// R10: controller must not toggle go-to rapidly
// R11: byte 2 low nibble fault, upper zero
// R12: priority faults 5, 6, 7
// R13: minor faults 9, 0x0a, 0x0b
// R14: major faults 0x0d, 0x0e, 0x0f latched
// R15: activation clear then set leaves major fault
// R16: fault lamp off, steady or blinking
// R17: byte 3 echoes finger A or common request
// R18: bytes 6, 9, 12 echo B, C, scissor
// R19: bytes 4, 7, 10, 13 actual positions
// R20: bytes 5, 8, 11, 14 motor currents
// R21: each word packs two bytes from 0x07d0
// R22: requests clamp to soft limits internally
// R23: bank is read-only, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "gsrb_regs.vh"

module gsrb_status_bank #(
  parameter [31:0] INTERF_CYCLES = `GSRB_INTERF_S * `GSRB_CLK_HZ,
  parameter [31:0] BLINK_CYCLES = `GSRB_BLINK_MS * (`GSRB_CLK_HZ / `GSRB_MS_PER_S)
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Word read port
  input wire rd_req,
  input wire [15:0] rd_addr,
  output reg [15:0] rd_data_q,
  output reg rd_valid_q,
  output reg rd_err_q,
  // Word write port
  input wire wr_req,
  input wire [15:0] wr_addr,
  input wire [15:0] wr_data,
  output reg wr_ignored_q,
  // Command-side requests
  input wire activation_request,
  input wire [1:0] grasp_mode_request,
  input wire goto_request,
  input wire individual_finger_select,
  input wire [7:0] finger_a_position_request,
  input wire [7:0] finger_b_position_request,
  input wire [7:0] finger_c_position_request,
  input wire [7:0] scissor_position_request,
  input wire [7:0] finger_a_force_request,
  input wire [7:0] finger_b_force_request,
  input wire [7:0] finger_c_force_request,
  input wire [7:0] scissor_force_request,
  // Measured positions
  input wire [7:0] finger_a_position,
  input wire [7:0] finger_b_position,
  input wire [7:0] finger_c_position,
  input wire [7:0] scissor_position,
  // Measured currents
  input wire [7:0] finger_a_current,
  input wire [7:0] finger_b_current,
  input wire [7:0] finger_c_current,
  input wire [7:0] scissor_current,
  // Contact pulses, bit per axis A, B, C, scissor
  input wire [3:0] contact_opening,
  input wire [3:0] contact_closing,
  // Soft limits
  input wire [7:0] finger_a_limit_open,
  input wire [7:0] finger_a_limit_close,
  input wire [7:0] finger_b_limit_open,
  input wire [7:0] finger_b_limit_close,
  input wire [7:0] finger_c_limit_open,
  input wire [7:0] finger_c_limit_close,
  input wire [7:0] scissor_limit_open,
  input wire [7:0] scissor_limit_close,
  // Motion controller events
  input wire activation_done,
  input wire activation_failed,
  input wire mode_change_done,
  input wire scissor_interference,
  input wire auto_release_active,
  input wire auto_release_done,
  input wire comm_ready,
  // Fault lamp
  output reg fault_led_q
);

  // Clamp a request into the soft-limit window
  function [7:0] gsrb_clamp;
    input [7:0] req;
    input [7:0] lo;
    input [7:0] hi;
    begin
      gsrb_clamp = (req < lo) ? lo : ((req > hi) ? hi : req);
    end
  endfunction

  // Contact code from stop latch and arrival
  function [1:0] gsrb_axis_code;
    input [1:0] stop;
    input reached;
    begin
      gsrb_axis_code = (stop != `GSRB_CT_MOVING) ? stop :
                       (reached ? `GSRB_CT_AT_REQUEST : `GSRB_CT_MOVING);
    end
  endfunction

  // Per-axis views, index A, B, C, scissor
  wire [7:0] req_w [0:3];
  wire [7:0] force_w [0:3];
  wire [7:0] pos_w [0:3];
  wire [7:0] lo_w [0:3];
  wire [7:0] hi_w [0:3];

  // Fingers B and C follow A unless driven individually
  assign req_w[`GSRB_AX_A] = finger_a_position_request;
  assign req_w[`GSRB_AX_B] = individual_finger_select ?
                             finger_b_position_request : finger_a_position_request;
  assign req_w[`GSRB_AX_C] = individual_finger_select ?
                             finger_c_position_request : finger_a_position_request;
  assign req_w[`GSRB_AX_S] = scissor_position_request;
  assign force_w[`GSRB_AX_A] = finger_a_force_request;
  assign force_w[`GSRB_AX_B] = individual_finger_select ?
                               finger_b_force_request : finger_a_force_request;
  assign force_w[`GSRB_AX_C] = individual_finger_select ?
                               finger_c_force_request : finger_a_force_request;
  assign force_w[`GSRB_AX_S] = scissor_force_request;
  assign pos_w[`GSRB_AX_A] = finger_a_position;
  assign pos_w[`GSRB_AX_B] = finger_b_position;
  assign pos_w[`GSRB_AX_C] = finger_c_position;
  assign pos_w[`GSRB_AX_S] = scissor_position;
  assign lo_w[`GSRB_AX_A] = finger_a_limit_open;
  assign lo_w[`GSRB_AX_B] = finger_b_limit_open;
  assign lo_w[`GSRB_AX_C] = finger_c_limit_open;
  assign lo_w[`GSRB_AX_S] = scissor_limit_open;
  assign hi_w[`GSRB_AX_A] = finger_a_limit_close;
  assign hi_w[`GSRB_AX_B] = finger_b_limit_close;
  assign hi_w[`GSRB_AX_C] = finger_c_limit_close;
  assign hi_w[`GSRB_AX_S] = scissor_limit_close;

  // State registers
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg act_prev_q;
  reg goto_prev_q;
  reg [1:0] mode_prev_q;
  reg [3:0] major_q;
  reg [3:0] major_d;
  reg [31:0] interf_cnt_q;
  reg [31:0] blink_cnt_q;
  reg blink_q;
  reg [1:0] stop_q [0:3];
  reg [7:0] req_prev_q [0:3];
  reg [7:0] force_prev_q [0:3];
  reg [7:0] bank_q [0:15];

  wire act_rise = activation_request && !act_prev_q;
  wire act_fall = !activation_request && act_prev_q;
  wire goto_rise = goto_request && !goto_prev_q;
  wire moving_ok = goto_request && (state_q == `GSRB_ST_READY);
  wire interf_on = scissor_interference && (state_q == `GSRB_ST_MODE_CHANGE);
  wire interf_long = interf_on && (interf_cnt_q >= INTERF_CYCLES);

  // Gripper state sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      `GSRB_ST_RESET: begin
        if (act_rise && (major_q == `GSRB_FLT_NONE)) begin
          state_d = `GSRB_ST_ACTIVATING; // R15
        end
      end
      `GSRB_ST_ACTIVATING: begin
        if (activation_done) begin
          state_d = `GSRB_ST_READY;
        end
      end
      `GSRB_ST_MODE_CHANGE: begin
        if (mode_change_done) begin
          state_d = `GSRB_ST_READY;
        end
      end
      `GSRB_ST_READY: begin
        if (grasp_mode_request != mode_prev_q) begin
          state_d = `GSRB_ST_MODE_CHANGE;
        end
      end
      default: begin
        state_d = `GSRB_ST_RESET;
      end
    endcase
    if (!activation_request || auto_release_active || activation_failed ||
        (major_q != `GSRB_FLT_NONE)) begin
      state_d = `GSRB_ST_RESET; // R4
    end
  end

  // Major fault latch, a new fault beats the clearing edge
  always @* begin
    major_d = major_q;
    if (act_fall) begin
      major_d = `GSRB_FLT_NONE; // R15
    end
    if (activation_failed) begin
      major_d = `GSRB_FLT_ACT_FAIL; // R14
    end else if (interf_long) begin
      major_d = `GSRB_FLT_INTERF_LONG; // R14
    end else if (auto_release_done) begin
      major_d = `GSRB_FLT_RELEASED; // R14
    end
  end

  // Fault code by priority
  reg [3:0] fault_d;
  always @* begin
    fault_d = `GSRB_FLT_NONE;
    if (major_q != `GSRB_FLT_NONE) begin
      fault_d = major_q; // R14
    end else if (auto_release_active) begin
      fault_d = `GSRB_FLT_RELEASING; // R13
    end else if (interf_on) begin
      fault_d = `GSRB_FLT_INTERF; // R13
    end else if (!comm_ready) begin
      fault_d = `GSRB_FLT_COMM; // R13
    end else if (goto_request && !activation_request) begin
      fault_d = `GSRB_FLT_NO_ACT; // R12
    end else if (goto_request && (state_q == `GSRB_ST_ACTIVATING)) begin
      fault_d = `GSRB_FLT_WAIT_ACT; // R12
    end else if (goto_request && (state_q == `GSRB_ST_MODE_CHANGE)) begin
      fault_d = `GSRB_FLT_WAIT_MODE; // R12
    end
  end

  // Contact codes and motion summary
  reg [1:0] code_d [0:3];
  reg [1:0] motion_d;
  reg [2:0] stopped_n;
  reg finger_moving;
  integer k;
  always @* begin
    stopped_n = 3'h0;
    finger_moving = 1'b0;
    for (k = 0; k < `GSRB_NUM_AXES; k = k + 1) begin
      code_d[k] = gsrb_axis_code(stop_q[k],
                                 pos_w[k] == gsrb_clamp(req_w[k], lo_w[k], hi_w[k])); // R7 R22
    end
    for (k = 0; k < `GSRB_NUM_AXES - 1; k = k + 1) begin
      if (code_d[k] == `GSRB_CT_MOVING) begin
        finger_moving = 1'b1;
      end
      if ((code_d[k] == `GSRB_CT_STOP_OPEN) || (code_d[k] == `GSRB_CT_STOP_CLOSE)) begin
        stopped_n = stopped_n + 3'h1;
      end
    end
    if (finger_moving) begin
      motion_d = `GSRB_MS_MOVING; // R5
    end else if (stopped_n == 3'h0) begin
      motion_d = `GSRB_MS_ALL_REACHED; // R5
    end else if (stopped_n == 3'h3) begin
      motion_d = `GSRB_MS_ALL_STOPPED; // R5
    end else begin
      motion_d = `GSRB_MS_SOME_STOPPED; // R5
    end
  end

  // Status bytes as seen this cycle
  reg [7:0] snap [0:15];
  always @* begin
    snap[`GSRB_GRIPPER_STATE] = {motion_d, state_q, goto_request,
                                 grasp_mode_request, activation_request}; // R1 R2 R3 R6
    snap[`GSRB_AXIS_CONTACT_STATE] = {code_d[`GSRB_AX_S], code_d[`GSRB_AX_C],
                                      code_d[`GSRB_AX_B], code_d[`GSRB_AX_A]}; // R8
    snap[`GSRB_FAULT_CODE] = {`GSRB_FLT_PAD, fault_d}; // R11
    snap[`GSRB_FINGER_A_REQUEST_ECHO] = finger_a_position_request; // R17
    snap[`GSRB_FINGER_A_ACTUAL_POSITION] = finger_a_position; // R19
    snap[`GSRB_FINGER_A_MOTOR_CURRENT] = finger_a_current; // R20
    snap[`GSRB_FINGER_B_REQUEST_ECHO] = finger_b_position_request; // R18
    snap[`GSRB_FINGER_B_ACTUAL_POSITION] = finger_b_position; // R19
    snap[`GSRB_FINGER_B_MOTOR_CURRENT] = finger_b_current; // R20
    snap[`GSRB_FINGER_C_REQUEST_ECHO] = finger_c_position_request; // R18
    snap[`GSRB_FINGER_C_ACTUAL_POSITION] = finger_c_position; // R19
    snap[`GSRB_FINGER_C_MOTOR_CURRENT] = finger_c_current; // R20
    snap[`GSRB_SCISSOR_REQUEST_ECHO] = scissor_position_request; // R18
    snap[`GSRB_SCISSOR_ACTUAL_POSITION] = scissor_position; // R19
    snap[`GSRB_SCISSOR_MOTOR_CURRENT] = scissor_current; // R20
    snap[`GSRB_PAD_BYTE] = 8'h00;
  end

  // Axis stop latches, a contact latches only a moving axis, so a re-arm in the same cycle wins on a stopped one
  integer j;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (j = 0; j < `GSRB_NUM_AXES; j = j + 1) begin
        stop_q[j] <= `GSRB_CT_MOVING;
        req_prev_q[j] <= 8'h00;
        force_prev_q[j] <= 8'h00;
      end
    end else begin
      for (j = 0; j < `GSRB_NUM_AXES; j = j + 1) begin
        req_prev_q[j] <= req_w[j];
        force_prev_q[j] <= force_w[j];
        if (!activation_request) begin
          stop_q[j] <= `GSRB_CT_MOVING;
        end else if (moving_ok && (stop_q[j] == `GSRB_CT_MOVING) && contact_closing[j]) begin
          stop_q[j] <= `GSRB_CT_STOP_CLOSE; // R7
        end else if (moving_ok && (stop_q[j] == `GSRB_CT_MOVING) && contact_opening[j]) begin
          stop_q[j] <= `GSRB_CT_STOP_OPEN; // R7
        end else if (goto_rise || (force_w[j] > force_prev_q[j]) ||
                     ((req_w[j] != req_prev_q[j]) &&
                      (((stop_q[j] == `GSRB_CT_STOP_CLOSE) && (req_w[j] < pos_w[j])) ||
                       ((stop_q[j] == `GSRB_CT_STOP_OPEN) && (req_w[j] > pos_w[j]))))) begin
          stop_q[j] <= `GSRB_CT_MOVING; // R9
        end
      end
    end
  end

  // Control state, interference timer and lamp
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `GSRB_ST_RESET;
      major_q <= `GSRB_FLT_NONE;
      act_prev_q <= 1'b0;
      goto_prev_q <= 1'b0;
      mode_prev_q <= 2'h0;
      interf_cnt_q <= 32'h0000_0000;
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
      fault_led_q <= 1'b0;
    end else begin
      state_q <= state_d;
      major_q <= major_d;
      act_prev_q <= activation_request;
      goto_prev_q <= goto_request;
      mode_prev_q <= grasp_mode_request;
      if (interf_on && !interf_long) begin
        interf_cnt_q <= interf_cnt_q + 32'h0000_0001;
      end else if (!interf_on) begin
        interf_cnt_q <= 32'h0000_0000;
      end
      if (blink_cnt_q >= BLINK_CYCLES - 32'h0000_0001) begin
        blink_cnt_q <= 32'h0000_0000;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
      // Major blinks, minor steady, others dark
      fault_led_q <= (fault_d >= `GSRB_FLT_ACT_FAIL) ? blink_q :
                     (fault_d >= `GSRB_FLT_COMM); // R16
    end
  end

  // Snapshot of the bank, refreshed every cycle
  integer b;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (b = 0; b < `GSRB_BANK_BYTES; b = b + 1) begin
        bank_q[b] <= 8'h00;
      end
    end else begin
      for (b = 0; b < `GSRB_BANK_BYTES; b = b + 1) begin
        bank_q[b] <= snap[b];
      end
    end
  end

  // Word decode
  wire [15:0] rd_off = rd_addr - `GSRB_WORD_BASE;
  wire rd_hit = (rd_addr >= `GSRB_WORD_BASE) && (rd_off < `GSRB_NUM_WORDS);
  wire [3:0] rd_byte = {rd_off[2:0], 1'b0};
  wire [15:0] wr_off = wr_addr - `GSRB_WORD_BASE;
  wire wr_hit = (wr_addr >= `GSRB_WORD_BASE) && (wr_off < `GSRB_NUM_WORDS);
  wire [15:0] wr_unused = wr_data;

  // Read answers one cycle later, byte pairs high first; writes dropped
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      rd_err_q <= 1'b0;
      wr_ignored_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req;
      rd_err_q <= rd_req && !rd_hit;
      wr_ignored_q <= wr_req && wr_hit && (wr_unused == wr_data); // R23
      if (rd_req && rd_hit) begin
        rd_data_q <= {bank_q[rd_byte], bank_q[rd_byte + 4'h1]}; // R21
      end else if (rd_req) begin
        rd_data_q <= 16'h0000;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verification/gsrb_mech_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gsrb_mech_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Requests, bytes scissor, C, B, A
  input wire logic [31:0] req,
  input wire logic indiv,
  input wire logic [3:0] hold,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  // Measured values
  output logic [31:0] pos,
  output logic [31:0] cur
);
  logic [31:0] tgt;

  // Mechanical targets, B and C follow A in common control
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tgt[8*i +: 8] = ((i == 1 || i == 2) && !indiv) ? req[7:0] : req[8*i +: 8];
      if (tgt[8*i +: 8] < lo) tgt[8*i +: 8] = lo;
      if (tgt[8*i +: 8] > hi) tgt[8*i +: 8] = hi;
    end
  end

  // Free axes settle in one cycle, held axes stay put
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos <= {4{lo}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!hold[i]) pos[8*i +: 8] <= tgt[8*i +: 8];
      end
    end
  end

  // Current drawn follows position
  assign cur = pos ^ {4{8'h5a}};
endmodule
`default_nettype wire

/* File: verification/gsrb_status_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module gsrb_status_bank_sva (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Register ports
  input wire rd_req,
  input wire [15:0] rd_addr,
  input wire [15:0] rd_data_q,
  input wire rd_valid_q,
  input wire rd_err_q,
  input wire wr_req,
  input wire [15:0] wr_addr,
  input wire wr_ignored_q,
  // Status sources
  input wire activation_request,
  input wire [1:0] grasp_mode_request,
  input wire goto_request,
  input wire [7:0] finger_a_position,
  input wire [7:0] finger_a_current,
  input wire [7:0] finger_b_position_request
);
  // Address decode of both ports
  wire rd_in = rd_addr >= 16'h07d0 && rd_addr <= 16'h07d7;
  wire wr_in = wr_addr >= 16'h07d0 && wr_addr <= 16'h07d7;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_read_answer: assert property (
    rd_req |=> rd_valid_q) else $error("read not answered");
  a_answer_cause: assert property (
    !rd_req |=> !rd_valid_q && !rd_err_q) else $error("answer without read");
  a_read_refused: assert property (
    rd_req && !rd_in |=> rd_err_q && rd_data_q == 16'h0000) else $error("bad read kept");
  a_read_inbank: assert property (
    rd_req && rd_in |=> !rd_err_q) else $error("bank read refused");
  a_write_seen: assert property (
    wr_req && wr_in |=> wr_ignored_q) else $error("bank write not flagged");
  a_write_quiet: assert property (
    !(wr_req && wr_in) |=> !wr_ignored_q) else $error("stray write flag");
  a_byte0_echo: assert property (
    rd_req && rd_addr == 16'h07d0 && $past(rstn) |=> rd_data_q[11:8] ==
    {$past(goto_request, 2), $past(grasp_mode_request, 2), $past(activation_request, 2)})
    else $error("command echo wrong");
  a_fault_upper: assert property (
    rd_req && rd_addr == 16'h07d1 |=> rd_data_q[15:12] == 4'h0) else $error("fault upper set");
  a_finger_a_word: assert property (
    rd_req && rd_addr == 16'h07d2 && $past(rstn) |=> rd_data_q ==
    {$past(finger_a_position, 2), $past(finger_a_current, 2)}) else $error("finger word wrong");
  a_echo_b: assert property (
    rd_req && rd_addr == 16'h07d3 && $past(rstn) |=> rd_data_q[15:8] ==
    $past(finger_b_position_request, 2)) else $error("echo wrong");
  a_pad_byte: assert property (
    rd_req && rd_addr == 16'h07d7 |=> rd_data_q[7:0] == 8'h00) else $error("pad byte set");

  c_refused: cover property (rd_req && !rd_in ##1 rd_err_q);
  c_write: cover property (wr_req && wr_in ##1 wr_ignored_q);
  c_active: cover property (rd_req && rd_addr == 16'h07d0 ##1 rd_data_q[8]);
endmodule
`default_nettype wire

/* File: verification/gsrb_status_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gsrb_status_bank_tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [15:0] rd_addr = 16'h0, wr_addr = 16'h0, wr_data = 16'h0;
  logic act = 1'b0, gto = 1'b0, indiv = 1'b0, comm = 1'b1, interf = 1'b0, ar_act = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] ra = 8'h0, rb = 8'h0, rc = 8'h0, rs = 8'h0, fa = 8'h0, fb = 8'h0;
  logic [7:0] fc = 8'h0, fs = 8'h0, lim_lo = 8'h10, lim_hi = 8'hf0;
  logic [3:0] hold = 4'h0;
  logic [11:0] ev = 12'h0;
  wire [31:0] pos, cur;
  wire [15:0] rd_data_q;
  wire rd_valid_q, rd_err_q, wr_ignored_q, fault_led_q;
  int mismatches = 0;
  int tests_run = 0;

  always #5 mclk = ~mclk;

  gsrb_status_bank #(.INTERF_CYCLES(32'd50), .BLINK_CYCLES(32'd4)) dut (
    .mclk(mclk), .rstn(rstn), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ignored_q(wr_ignored_q), .activation_request(act),
    .grasp_mode_request(mode), .goto_request(gto), .individual_finger_select(indiv),
    .finger_a_position_request(ra), .finger_b_position_request(rb),
    .finger_c_position_request(rc), .scissor_position_request(rs),
    .finger_a_force_request(fa), .finger_b_force_request(fb),
    .finger_c_force_request(fc), .scissor_force_request(fs),
    .finger_a_position(pos[7:0]), .finger_b_position(pos[15:8]),
    .finger_c_position(pos[23:16]), .scissor_position(pos[31:24]),
    .finger_a_current(cur[7:0]), .finger_b_current(cur[15:8]),
    .finger_c_current(cur[23:16]), .scissor_current(cur[31:24]),
    .contact_opening(ev[7:4]), .contact_closing(ev[11:8]),
    .finger_a_limit_open(lim_lo), .finger_a_limit_close(lim_hi),
    .finger_b_limit_open(lim_lo), .finger_b_limit_close(lim_hi),
    .finger_c_limit_open(lim_lo), .finger_c_limit_close(lim_hi),
    .scissor_limit_open(lim_lo), .scissor_limit_close(lim_hi),
    .activation_done(ev[0]), .activation_failed(ev[1]), .mode_change_done(ev[2]),
    .scissor_interference(interf), .auto_release_active(ar_act),
    .auto_release_done(ev[3]), .comm_ready(comm), .fault_led_q(fault_led_q));

  gsrb_mech_model u_mech (.mclk(mclk), .rstn(rstn), .req({rs, rc, rb, ra}), .indiv(indiv),
    .hold(hold), .lo(lim_lo), .hi(lim_hi), .pos(pos), .cur(cur));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One word read, result is {refused, data}
  task automatic rd(input logic [15:0] a, output logic [16:0] r);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_req = 1'b0;
    r = {rd_err_q, rd_data_q};
    check(rd_valid_q, 1'b1);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    logic [16:0] r;
    rd(a, r);
    check(r, {1'b0, exp});
  endtask

  // One word write, flag expected only inside the bank
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    wr_req = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_req = 1'b0;
    check(wr_ignored_q, a >= 16'h07d0 && a <= 16'h07d7);
  endtask

  task automatic pulse(input logic [11:0] m);
    ev = m;
    tick(1);
    ev = 12'h0;
    tick(3);
  endtask

  function automatic logic [7:0] b0(input logic [1:0] mo, input logic [1:0] st);
    return {mo, st, gto, mode, act};
  endfunction

  // Activation cycled off then on to leave a fault
  task automatic recover();
    act = 1'b0;
    tick(3);
    act = 1'b1;
    tick(3);
    rdc(16'h07d1, {8'h05, ra});
    check(fault_led_q, 1'b0);
    pulse(12'h001);
    rdc(16'h07d1, {8'h00, ra});
  endtask

  task automatic final_report();
    $display("TB counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (4000) @(posedge mclk);
    mismatches++;
    final_report();
  end

  initial begin
    logic [16:0] r;
    logic [7:0] bytes [16];
    logic [7:0] v;
    int n;
    logic p;
    tick(12);
    rstn = 1'b1;
    tick(3);
    rdc(16'h07d0, {b0(2'h3, 2'h0), 8'hff});
    rdc(16'h07d1, 16'h0000);
    wr(16'h07d1, 16'hffff);
    wr(16'h07cf, 16'hffff);
    rdc(16'h07d1, 16'h0000);
    rdc(16'h07d7, 16'h4a00);
    rd(16'h07d8, r);
    check(r, 17'h10000);
    $display("test idle done");
    gto = 1'b1;
    tick(3);
    rdc(16'h07d1, 16'h0700);
    comm = 1'b0;
    tick(3);
    rdc(16'h07d1, 16'h0900);
    comm = 1'b1;
    act = 1'b1;
    tick(3);
    rdc(16'h07d0, {b0(2'h3, 2'h1), 8'hff});
    rdc(16'h07d1, 16'h0500);
    pulse(12'h001);
    rdc(16'h07d0, {b0(2'h3, 2'h3), 8'hff});
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      tick(3);
      rd(16'h07d0, r);
      check(r[10:9], m);
      pulse(12'h004);
    end
    mode = 2'h2;
    tick(3);
    rdc(16'h07d1, 16'h0600);
    interf = 1'b1;
    tick(3);
    rdc(16'h07d1, 16'h0a00);
    check(fault_led_q, 1'b1);
    tick(60);
    rdc(16'h07d1, 16'h0e00);
    rd(16'h07d0, r);
    check(r[13:12], 2'h0);
    n = 0;
    p = fault_led_q;
    repeat (16) begin
      tick(1);
      n += (fault_led_q !== p);
      p = fault_led_q;
    end
    check(n, 4);
    interf = 1'b0;
    recover();
    $display("test faults done");
    ar_act = 1'b1;
    comm = 1'b0;
    tick(3);
    rdc(16'h07d1, 16'h0b00);
    check(fault_led_q, 1'b1);
    rd(16'h07d0, r);
    check(r[13:12], 2'h0);
    tick(8);
    check(fault_led_q, 1'b1);
    pulse(12'h008);
    ar_act = 1'b0;
    comm = 1'b1;
    tick(3);
    rdc(16'h07d1, 16'h0f00);
    recover();
    pulse(12'h002);
    rdc(16'h07d1, 16'h0d00);
    recover();
    $display("test release done");
    hold = 4'h1;
    ra = 8'h80;
    tick(3);
    rdc(16'h07d0, {b0(2'h0, 2'h3), 8'hfc});
    pulse(12'h100);
    rdc(16'h07d0, {b0(2'h1, 2'h3), 8'hfe});
    ra = 8'h08;
    tick(3);
    rdc(16'h07d0, {b0(2'h3, 2'h3), 8'hff});
    hold = 4'hf;
    ra = 8'hc0;
    rs = 8'hc0;
    tick(3);
    pulse(12'hf00);
    rdc(16'h07d0, {b0(2'h2, 2'h3), 8'haa});
    gto = 1'b0;
    tick(20);
    gto = 1'b1;
    tick(3);
    rdc(16'h07d0, {b0(2'h0, 2'h3), 8'h00});
    pulse(12'h020);
    rdc(16'h07d0, {b0(2'h0, 2'h3), 8'h04});
    fa = 8'h40;
    tick(3);
    rdc(16'h07d0, {b0(2'h0, 2'h3), 8'h00});
    $display("test contacts done");
    indiv = 1'b1;
    hold = 4'h0;
    {rs, rc, rb, ra} = 32'h50403020;
    tick(4);
    bytes[2] = 8'h00;
    bytes[15] = 8'h00;
    for (int i = 0; i < 4; i++) begin
      v = {i[3:0] + 4'h2, 4'h0};
      bytes[3 + 3 * i] = v;
      bytes[4 + 3 * i] = v;
      bytes[5 + 3 * i] = v ^ 8'h5a;
    end
    for (int w = 1; w < 8; w++) begin
      rdc(16'h07d0 + w[15:0], {bytes[2 * w], bytes[2 * w + 1]});
    end
    $display("test echo done");
    final_report();
  end
endmodule

bind gsrb_status_bank gsrb_status_bank_sva u_sva (.mclk(mclk), .rstn(rstn),
  .rd_req(rd_req), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .rd_err_q(rd_err_q), .wr_req(wr_req), .wr_addr(wr_addr), .wr_ignored_q(wr_ignored_q),
  .activation_request(activation_request), .grasp_mode_request(grasp_mode_request),
  .goto_request(goto_request), .finger_a_position(finger_a_position),
  .finger_a_current(finger_a_current), .finger_b_position_request(finger_b_position_request));
`default_nettype wire
